/* logic/radio_front_end_params.svh */
/*
  Offsets, field positions, reset values and timing counts for the
  front-end mode and calibration control block. Assumes a 32-bit APB.
*/
`ifndef RADIO_FRONT_END_PARAMS_SVH
`define RADIO_FRONT_END_PARAMS_SVH
// Register byte offsets
`define CTRL_OFF     12'h000
`define RF_OFF       12'h004
`define IF_OFF       12'h008
`define STAT_OFF     12'h00C
// Control register fields
`define PS_LSB       0
`define BAND_BIT     2
`define IFFRAC_BIT   3
`define HALF_BIT     4
// Synthesizer register fields, shared by RF and IF
`define CC_LSB       0
`define SUB_LSB      8
`define NUM_LSB      16
`define MOD_LSB      24
// Reset values
`define PS_RST       2'h0
`define BAND_RST     1'h0
`define IFFRAC_RST   1'h0
`define HALF_RST     1'h1
`define RF_CC_RST    5'h0A
`define RF_SUB_RST   3'h0
`define RF_NUM_RST   7'h30
`define RF_MOD_RST   7'h4F
`define IF_CC_RST    5'h10
`define IF_SUB_RST   3'h2
`define IF_NUM_RST   7'h20
`define IF_MOD_RST   7'h4F
// Calibration timing: longest run, ticks of 1 us at 100 MHz
`define CLK_NS       10
`define CAL_TICK_NS  1000
`define CAL_TICKS    68
`define CAL_CYCLES   ((`CAL_TICKS * `CAL_TICK_NS) / `CLK_NS)
`endif

/* logic/radio_front_end_pkg.sv */
/*
  Types for the front-end mode and calibration control block.
  Assumes nothing of its surroundings.
*/
package radio_front_end_pkg;
  // Calibration sequence
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_HOLD
  } cal_state_t;
endpackage

/* logic/pin_sync.sv */
/*
  Three-stage synchroniser for a group of pin inputs.
  Assumes pins are asynchronous to pclk; a change is passed on once
  the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  // Refuse an empty pin group at elaboration
  if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");

  // One chain per pin; only stage two reads stage one
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q       <= 1'b0;
        s2_q       <= 1'b0;
        s3_q       <= 1'b0;
        pin_out[i] <= 1'b0;
      end else begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) pin_out[i] <= s3_q;
      end
    end
  end
endmodule

/* logic/radio_front_end_ctrl.sv */
/*
  Mode decoder, front-end power outputs, receive offset calibration
  sequencer and synthesizer settings, with an APB register slave.
  Assumes pins and lock flags are asynchronous to pclk, a 100 MHz pclk,
  and a zero-wait APB master.
*/
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "radio_front_end_params.svh"

// Summary of operation
// - Pin low: amps off, front end asleep, band low, everything off.
// - Standby: oscillator and port on; synths, TX, RX off; outputs idle.
// - Idle: synthesizers on, TX and RX off, outputs as in standby.
// - Active, amp enable low: front end awake, band follows choice.
// - Active receive: RX on, TX off, amps off, band from choice.
// - Transmit on band A: amp A on, amp B off, band high.
// - Transmit on band B: amp B on, amp A off, band low.
// - Calibration start puts front end asleep until done, trigger low or receive mode left.
// - Calibration runs only in receive active mode.
// - Status is low while calibration runs, high again when done.
// - RF divider is 8*(coarse+3) minus subtract, fraction num/(mod+1).
// - RF fields default to halving 1, 10, 0, 48 and 79.
// - IF synthesizer defaults to integer mode.
// - Band choice 1 selects band A, 0 selects band B.
// - Fractional IF acts only in idle or active mode.
// - Fields take defaults at power-up and at each chip-on rise.
module radio_front_end_ctrl #(
  parameter int AW         = 12,
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          chip_on_pin,
  input  wire logic          tx_rx_select,
  input  wire logic          amp_enable_pin,
  input  wire logic          offset_cal_trigger,
  input  wire logic          rf_locked,
  input  wire logic          if_locked,
  output logic               amp_off_band_a,
  output logic               amp_off_band_b,
  output logic               front_end_sleep,
  output logic               band_select_out,
  output logic               tx_on,
  output logic               rx_on,
  output logic               synth_on,
  output logic               osc_on,
  output logic               serial_on,
  output logic               cal_active,
  output logic               if_frac_active,
  output logic               status,
  output logic               ref_halving,
  output logic [8:0]         rf_int_div,
  output logic [6:0]         rf_numerator,
  output logic [6:0]         rf_modulus,
  output logic [4:0]         if_coarse_count,
  output logic [2:0]         if_subtract,
  output logic [6:0]         if_numerator,
  output logic [6:0]         if_modulus
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  // Refuse sizes the decode and counter cannot serve
  if (AW < 4) $error("radio_front_end_ctrl: AW must be at least 4");
  if (CAL_CYCLES < 2) $error("radio_front_end_ctrl: CAL_CYCLES below 2");

  typedef struct packed {
    logic [1:0]          power_state;
    logic                band_choice;
    logic                if_fractional_on;
    logic                ref_halving;
    logic [4:0]          rf_coarse_count;
    logic [2:0]          rf_subtract;
    logic [6:0]          rf_numerator;
    logic [6:0]          rf_modulus;
    logic [4:0]          if_coarse_count;
    logic [2:0]          if_subtract;
    logic [6:0]          if_numerator;
    logic [6:0]          if_modulus;
    radio_front_end_pkg::cal_state_t cal;
    logic [CW-1:0]       cnt;
    logic                on_prev, trig_prev;
    logic                amp_a;
    logic                amp_b;
    logic                fe_sleep;
    logic                bsel;
    logic                tx, rx;
    logic                syn, osc;
    logic                stat;
    logic                iffrac;
    logic [8:0]          rf_int;
    logic [31:0]         rdata;
    logic                err;
  } state_t;

  localparam state_t S_RST = '{
    power_state:      `PS_RST,
    band_choice:      `BAND_RST,
    if_fractional_on: `IFFRAC_RST,
    ref_halving:      `HALF_RST,
    rf_coarse_count:  `RF_CC_RST,
    rf_subtract:      `RF_SUB_RST,
    rf_numerator:     `RF_NUM_RST,
    rf_modulus:       `RF_MOD_RST,
    if_coarse_count:  `IF_CC_RST,
    if_subtract:      `IF_SUB_RST,
    if_numerator:     `IF_NUM_RST,
    if_modulus:       `IF_MOD_RST,
    cal:              radio_front_end_pkg::CAL_IDLE,
    amp_a:            1'b1,
    amp_b:            1'b1,
    fe_sleep:         1'b1,
    rf_int:           9'h068,
    default:          '0
  };

  state_t     s_q;
  state_t     s_d;
  logic [5:0] sync_s;
  logic       on_s, tr_s, pae_s, trig_s, lock_s;
  logic       active, rx_act, tx_mode;
  logic       setup, wr_en, hit;

  // Pins and lock flags into the pclk domain
  pin_sync #(.WIDTH(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({if_locked, rf_locked, offset_cal_trigger,
               amp_enable_pin, tx_rx_select, chip_on_pin}),
    .pin_out (sync_s)
  );
  assign on_s   = sync_s[0];
  assign tr_s   = sync_s[1];
  assign pae_s  = sync_s[2];
  assign trig_s = sync_s[3];
  assign lock_s = sync_s[4] & sync_s[5];

  // Mode decode from pin and power field
  assign active  = on_s & (s_q.power_state == 2'h3);
  assign rx_act  = active & ~tr_s;
  assign tx_mode = active & tr_s & pae_s;
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign hit     = (paddr == AW'(`CTRL_OFF)) | (paddr == AW'(`RF_OFF))
                 | (paddr == AW'(`IF_OFF)) | (paddr == AW'(`STAT_OFF));

  // Next state: registers, calibration, outputs, bus answer
  always_comb begin
    s_d           = s_q;
    // Chip-on rise restores every field; bus answer kept
    if (on_s && !s_q.on_prev) begin
      s_d       = S_RST;
      s_d.rdata = s_q.rdata;
      s_d.err   = s_q.err;
    end
    s_d.on_prev   = on_s;
    s_d.trig_prev = trig_s;
    // Writes land in access phase; refused asleep or at chip-on rise
    if (wr_en && on_s && s_q.on_prev) begin
      if (paddr == AW'(`CTRL_OFF)) begin
        s_d.power_state      = pwdata[`PS_LSB +: 2];
        s_d.band_choice      = pwdata[`BAND_BIT];
        s_d.if_fractional_on = pwdata[`IFFRAC_BIT];
        s_d.ref_halving      = pwdata[`HALF_BIT];
      end
      if (paddr == AW'(`RF_OFF)) begin
        s_d.rf_coarse_count = pwdata[`CC_LSB +: 5];
        s_d.rf_subtract     = pwdata[`SUB_LSB +: 3];
        s_d.rf_numerator    = pwdata[`NUM_LSB +: 7];
        s_d.rf_modulus      = pwdata[`MOD_LSB +: 7];
      end
      if (paddr == AW'(`IF_OFF)) begin
        s_d.if_coarse_count = pwdata[`CC_LSB +: 5];
        s_d.if_subtract     = pwdata[`SUB_LSB +: 3];
        s_d.if_numerator    = pwdata[`NUM_LSB +: 7];
        s_d.if_modulus      = pwdata[`MOD_LSB +: 7];
      end
    end
    // Calibration sequence, restarts need a fresh trigger edge
    case (s_q.cal)
      radio_front_end_pkg::CAL_IDLE: begin
        s_d.cnt = '0;
        if (trig_s && !s_q.trig_prev && rx_act) begin
          s_d.cal = radio_front_end_pkg::CAL_RUN;
        end
      end
      radio_front_end_pkg::CAL_RUN: begin
        if (!trig_s || !rx_act) begin
          s_d.cal = radio_front_end_pkg::CAL_IDLE;
        end else if (s_q.cnt == CW'(CAL_CYCLES - 1)) begin
          s_d.cal = radio_front_end_pkg::CAL_HOLD;
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end
      radio_front_end_pkg::CAL_HOLD: begin
        // Result kept while trigger high and not asleep
        if (!trig_s || !on_s) s_d.cal = radio_front_end_pkg::CAL_IDLE;
      end
      default: s_d.cal = radio_front_end_pkg::CAL_IDLE;
    endcase
    // Front-end drive from mode and calibration
    s_d.amp_a    = ~(tx_mode & s_q.band_choice);
    s_d.amp_b    = ~(tx_mode & ~s_q.band_choice);
    s_d.fe_sleep = ~active | (s_d.cal == radio_front_end_pkg::CAL_RUN);
    s_d.bsel     = active & s_q.band_choice;
    s_d.tx       = active & tr_s;
    s_d.rx       = active & ~tx_mode;
    s_d.syn      = on_s & s_q.power_state[0];
    s_d.osc      = on_s;
    s_d.iffrac   = s_q.if_fractional_on & s_d.syn;
    s_d.stat     = lock_s & s_d.syn
                 & (s_d.cal != radio_front_end_pkg::CAL_RUN);
    // RF integer divide: 8*(coarse+3) - subtract
    s_d.rf_int   = ({4'h0, s_q.rf_coarse_count} + 9'h003) * 9'h008
                 - {6'h00, s_q.rf_subtract};
    // Read data and error taken in the setup phase
    if (setup) begin
      s_d.err   = ~hit | (pwrite & (~on_s | (paddr == AW'(`STAT_OFF))));
      s_d.rdata = '0;
      if (!pwrite && paddr == AW'(`CTRL_OFF)) begin
        s_d.rdata[`PS_LSB +: 2]  = s_q.power_state;
        s_d.rdata[`BAND_BIT]     = s_q.band_choice;
        s_d.rdata[`IFFRAC_BIT]   = s_q.if_fractional_on;
        s_d.rdata[`HALF_BIT]     = s_q.ref_halving;
      end
      if (!pwrite && paddr == AW'(`RF_OFF)) begin
        s_d.rdata[`CC_LSB +: 5]  = s_q.rf_coarse_count;
        s_d.rdata[`SUB_LSB +: 3] = s_q.rf_subtract;
        s_d.rdata[`NUM_LSB +: 7] = s_q.rf_numerator;
        s_d.rdata[`MOD_LSB +: 7] = s_q.rf_modulus;
      end
      if (!pwrite && paddr == AW'(`IF_OFF)) begin
        s_d.rdata[`CC_LSB +: 5]  = s_q.if_coarse_count;
        s_d.rdata[`SUB_LSB +: 3] = s_q.if_subtract;
        s_d.rdata[`NUM_LSB +: 7] = s_q.if_numerator;
        s_d.rdata[`MOD_LSB +: 7] = s_q.if_modulus;
      end
      if (!pwrite && paddr == AW'(`STAT_OFF)) begin
        s_d.rdata[11:0] = {s_q.cal, s_q.iffrac, s_q.syn, s_q.rx,
                           s_q.tx, s_q.bsel, s_q.fe_sleep, s_q.amp_b,
                           s_q.amp_a, s_q.stat, on_s};
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register; pready tied high
  assign pready          = 1'b1;
  assign prdata          = s_q.rdata;
  assign pslverr         = s_q.err;
  assign amp_off_band_a  = s_q.amp_a;
  assign amp_off_band_b  = s_q.amp_b;
  assign front_end_sleep = s_q.fe_sleep;
  assign band_select_out = s_q.bsel;
  assign tx_on           = s_q.tx;
  assign rx_on           = s_q.rx;
  assign synth_on        = s_q.syn;
  assign osc_on          = s_q.osc;
  assign serial_on       = s_q.osc;
  assign cal_active      = (s_q.cal != radio_front_end_pkg::CAL_IDLE);
  assign if_frac_active  = s_q.iffrac;
  assign status          = s_q.stat;
  assign ref_halving     = s_q.ref_halving;
  assign rf_int_div      = s_q.rf_int;
  assign rf_numerator    = s_q.rf_numerator;
  assign rf_modulus      = s_q.rf_modulus;
  assign if_coarse_count = s_q.if_coarse_count;
  assign if_subtract     = s_q.if_subtract;
  assign if_numerator    = s_q.if_numerator;
  assign if_modulus      = s_q.if_modulus;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sleep;
    !on_s |=> amp_off_band_a && amp_off_band_b && front_end_sleep
              && !band_select_out && !osc_on && !synth_on;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep outputs wrong");
  property p_standby;
    on_s && !s_q.power_state[0] |=> !synth_on && !tx_on && !rx_on
      && osc_on && amp_off_band_a && amp_off_band_b && front_end_sleep;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby outputs wrong");
  property p_idle;
    on_s && s_q.power_state == 2'h1 |=> synth_on && !tx_on && !rx_on
      && front_end_sleep && !band_select_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle outputs wrong");
  property p_band;
    active |=> band_select_out == $past(s_q.band_choice);
  endproperty
  a_band: assert property (p_band)
    else $error("band select does not follow choice");
  property p_rx;
    rx_act |=> rx_on && !tx_on && amp_off_band_a && amp_off_band_b;
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive outputs wrong");
  property p_tx_a;
    tx_mode && s_q.band_choice |=> !amp_off_band_a && amp_off_band_b
      && band_select_out && tx_on && !rx_on && !front_end_sleep;
  endproperty
  a_tx_a: assert property (p_tx_a)
    else $error("band A transmit wrong");
  property p_tx_b;
    tx_mode && !s_q.band_choice |=> amp_off_band_a && !amp_off_band_b
      && !band_select_out && tx_on && !rx_on;
  endproperty
  a_tx_b: assert property (p_tx_b)
    else $error("band B transmit wrong");
  property p_cal_run;
    s_q.cal == radio_front_end_pkg::CAL_RUN |-> front_end_sleep && !status
      && $past(rx_act);
  endproperty
  a_cal_run: assert property (p_cal_run)
    else $error("calibration run outputs wrong");
  property p_cal_len;
    $rose(s_q.cal == radio_front_end_pkg::CAL_RUN) && trig_s && rx_act
      |-> (s_q.cal == radio_front_end_pkg::CAL_RUN)[*2];
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration ended too soon");
  property p_defaults;
    on_s && !s_q.on_prev |=> s_q.rf_coarse_count == `RF_CC_RST
      && s_q.rf_modulus == `RF_MOD_RST && !s_q.if_fractional_on;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("fields not restored on chip-on");
  property p_div;
    ##1 rf_int_div == 9'(($past(s_q.rf_coarse_count) + 9'h003) * 8
      - $past(s_q.rf_subtract));
  endproperty
  a_div: assert property (p_div)
    else $error("RF divide wrong");
  property p_iffrac;
    if_frac_active |-> synth_on;
  endproperty
  a_iffrac: assert property (p_iffrac)
    else $error("fractional IF outside idle or active");

  c_tx_a: cover property (tx_mode && s_q.band_choice);
  c_hold: cover property (s_q.cal == radio_front_end_pkg::CAL_HOLD);
  c_abort: cover property (s_q.cal == radio_front_end_pkg::CAL_RUN && !trig_s);
  c_on: cover property (on_s && !s_q.on_prev);
endmodule

/* dv/radio_front_end_front_end_model.sv */
/*
  Behavioural model of the external radio front end behind its
  P-MOSFET switches. Assumes each switch gate is driven by the block
  and conducts while its gate is low.
*/
`timescale 1ns/1ps
module radio_front_end_front_end_model (
  input  wire logic amp_off_band_a,
  input  wire logic amp_off_band_b,
  input  wire logic front_end_sleep,
  input  wire logic band_select_out,
  output logic      fe_powered,
  output logic      pa_a_powered,
  output logic      pa_b_powered,
  output logic      band_a_path
);
  // Low gate turns a switch on; amps need the front end powered too
  assign fe_powered   = (front_end_sleep === 1'b0);
  assign pa_a_powered = fe_powered && (amp_off_band_a === 1'b0);
  assign pa_b_powered = fe_powered && (amp_off_band_b === 1'b0);
  // Band path is undefined while asleep, so it reads as band B
  assign band_a_path  = fe_powered && (band_select_out === 1'b1);
endmodule

/* dv/radio_front_end_ctrl_tb.sv */
/*
  Self-checking bench for the front-end mode and calibration control.
  Assumes the register map and timing of the designer's hand-over.
*/
`timescale 1ns/1ps
`include "radio_front_end_params.svh"
module radio_front_end_mode_and_cal_control_tb;
  localparam int CAL = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic chip_on_pin, tx_rx_select, amp_enable_pin, offset_cal_trigger;
  logic rf_locked, if_locked, amp_off_band_a, amp_off_band_b;
  logic front_end_sleep, band_select_out, tx_on, rx_on, synth_on;
  logic osc_on, serial_on, cal_active, if_frac_active, status;
  logic ref_halving, fe_pw, pa_a_pw, pa_b_pw, band_a;
  logic [8:0] rf_int_div, mo;
  logic [6:0] rf_numerator, rf_modulus, if_numerator, if_modulus;
  logic [4:0] if_coarse_count;
  logic [2:0] if_subtract;
  int error_cnt = 0;
  int checks = 0;

  radio_front_end_ctrl #(
    .AW         (12),
    .CAL_CYCLES (CAL)
  ) u_dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .chip_on_pin        (chip_on_pin),
    .tx_rx_select       (tx_rx_select),
    .amp_enable_pin     (amp_enable_pin),
    .offset_cal_trigger (offset_cal_trigger),
    .rf_locked          (rf_locked),
    .if_locked          (if_locked),
    .amp_off_band_a     (amp_off_band_a),
    .amp_off_band_b     (amp_off_band_b),
    .front_end_sleep    (front_end_sleep),
    .band_select_out    (band_select_out),
    .tx_on              (tx_on),
    .rx_on              (rx_on),
    .synth_on           (synth_on),
    .osc_on             (osc_on),
    .serial_on          (serial_on),
    .cal_active         (cal_active),
    .if_frac_active     (if_frac_active),
    .status             (status),
    .ref_halving        (ref_halving),
    .rf_int_div         (rf_int_div),
    .rf_numerator       (rf_numerator),
    .rf_modulus         (rf_modulus),
    .if_coarse_count    (if_coarse_count),
    .if_subtract        (if_subtract),
    .if_numerator       (if_numerator),
    .if_modulus         (if_modulus)
  );
  radio_front_end_front_end_model u_fe (
    .amp_off_band_a (amp_off_band_a),
    .amp_off_band_b (amp_off_band_b),
    .front_end_sleep(front_end_sleep),
    .band_select_out(band_select_out),
    .fe_powered     (fe_pw),
    .pa_a_powered   (pa_a_pw),
    .pa_b_powered   (pa_b_pw),
    .band_a_path    (band_a)
  );
  // Mode outputs gathered for one comparison
  assign mo = {amp_off_band_a, amp_off_band_b, front_end_sleep,
               band_select_out, tx_on, rx_on, synth_on, osc_on, serial_on};

  // Clock source
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; waits for pready at the sampling edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pin change, then let synchroniser and output flops settle
  task automatic pins(input logic pe, tr, pae, cal);
    @(posedge pclk);
    chip_on_pin        <= pe;
    tx_rx_select       <= tr;
    amp_enable_pin     <= pae;
    offset_cal_trigger <= cal;
    repeat (8) @(posedge pclk);
  endtask

  task automatic wait_st(input logic v, output int n);
    n = 0;
    while (status !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(status, v);
  endtask

  task automatic t_defaults;
    chk({ref_halving, rf_int_div, rf_numerator, rf_modulus},
        {1'h1, 9'h068, 7'h30, 7'h4F});
    chk({if_coarse_count, if_subtract, if_numerator, if_modulus,
         if_frac_active}, {5'h10, 3'h2, 7'h20, 7'h4F, 1'h0});
    apb(1'b0, `RF_OFF, 32'h0);
    chk(rd, 32'h4F30000A);
    chk(mo, 9'h1C0);
    chk({fe_pw, pa_a_pw, pa_b_pw}, 3'h0);
    apb(1'b1, `CTRL_OFF, 32'h00000013);
    chk(pslverr, 1'b1);
  endtask

  task automatic t_modes;
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk(mo, 9'h1C3);
    apb(1'b1, `CTRL_OFF, 32'h0000001A);
    repeat (3) @(posedge pclk);
    chk({mo, if_frac_active}, {9'h1C3, 1'b0});
    apb(1'b1, `CTRL_OFF, 32'h00000019);
    repeat (3) @(posedge pclk);
    chk({mo, if_frac_active}, {9'h1C7, 1'b1});
    apb(1'b0, 12'h010, 32'h0);
    chk({pslverr, rd}, {1'b1, 32'h0});
    apb(1'b1, `STAT_OFF, 32'hFFFFFFFF);
    chk({pready, pslverr}, 2'h3);
  endtask

  task automatic t_active;
    logic tr, pae, bd;
    for (int i = 0; i < 8; i++) begin
      {tr, pae, bd} = i[2:0];
      apb(1'b1, `CTRL_OFF, {27'h0, 1'b1, 1'b1, bd, 2'h3});
      pins(1'b1, tr, pae, 1'b0);
      chk(mo, {!(tr && pae && bd), !(tr && pae && !bd), 1'b0, bd,
               tr, !(tr && pae), 3'h7});
      chk({pa_a_pw, pa_b_pw, band_a},
          {tr && pae && bd, tr && pae && !bd, bd});
    end
  endtask

  task automatic t_cal;
    int n;
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    wait_st(1'b1, n);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    wait_st(1'b0, n);
    chk({front_end_sleep, cal_active}, 2'h3);
    wait_st(1'b1, n);
    chk(n >= CAL - 2 && n <= CAL + 2, 1'b1);
    chk({front_end_sleep, cal_active}, 2'h1);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk(cal_active, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    chk({front_end_sleep, status}, 2'h2);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk({front_end_sleep, cal_active, status}, 3'h1);
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    chk({front_end_sleep, cal_active, status}, 3'h1);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
  endtask

  task automatic t_synth;
    apb(1'b1, `RF_OFF, 32'h7F64071F);
    apb(1'b1, `IF_OFF, 32'h4F200210);
    repeat (2) @(posedge pclk);
    chk({rf_int_div, rf_numerator, rf_modulus},
        {9'h109, 7'h64, 7'h7F});
    chk({if_coarse_count, if_subtract, if_numerator, if_modulus,
         if_frac_active}, {5'h10, 3'h2, 7'h20, 7'h4F, 1'h1});
    apb(1'b1, `RF_OFF, 32'h20000007);
    apb(1'b1, `CTRL_OFF, 32'h00000003);
    repeat (2) @(posedge pclk);
    chk({ref_halving, rf_int_div}, {1'b0, 9'h050});
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk(mo, 9'h1C0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b0, `RF_OFF, 32'h0);
    chk(rd, 32'h4F30000A);
    apb(1'b0, `CTRL_OFF, 32'h0);
    chk(rd, 32'h00000010);
    chk(rf_int_div, 9'h068);
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    test_done();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    chip_on_pin = 1'b0;
    tx_rx_select = 1'b0;
    amp_enable_pin = 1'b0;
    offset_cal_trigger = 1'b0;
    rf_locked = 1'b1;
    if_locked = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    t_defaults();
    t_modes();
    t_active();
    t_cal();
    t_synth();
    test_done();
  end
endmodule
